// ===== ssrw_pkg.sv
// Package: constants and carrier types for the supply supervisor reset block
package ssrw_pkg;
    // Time base and periods
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam real WDT_LONG_S = 35.0;
    localparam real WDT_NORM_S = 1.12;
    localparam real RST_TIMEOUT_S = 0.00112;
    // Least times round up to whole cycles
    localparam longint WDT_LONG_CYC = longint'($ceil(WDT_LONG_S * CLK_HZ));
    localparam longint WDT_NORM_CYC = longint'($ceil(WDT_NORM_S * CLK_HZ));
    localparam longint RST_TIMEOUT_CYC =
        longint'($ceil(RST_TIMEOUT_S * CLK_HZ));
    localparam int CNT_W = 34;
    localparam int MR_DEB_CYC = 65536;
    localparam int DEB_W = 17;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [2:0] SYNC_RST_HI = 3'h7;

    // Comparator flags arriving from the analog front end, high = bad
    typedef struct packed {
        logic primary_low;
        logic secondary_low;
        logic aux_low;
        logic pf_low;
    } ssrw_sense_t;

    // Reset outputs
    typedef struct packed {
        logic reset_out_n_a;
        logic reset_out_n_b;
        logic reset_out;
    } ssrw_rst_t;

    typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_NORMAL} ssrw_wd_t;
endpackage

// ===== ssrw_top.sv
// Top: reset generator with undervoltage, manual reset and dual watchdog
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Any undervoltage flag or low manual request asserts every reset output.
// - Reset holds until all causes clear, then one full timeout.
// - Undervoltage returning during the timeout restarts the count from zero.
// - Manual request low holds reset, plus one timeout after release.
// - Manual request is debounced internally, one clean reset results.
// - Strobe steady longer than current watchdog period asserts reset.
// - Floating strobe disables the watchdog entirely.
// - Every reset event puts watchdog in long initial mode.
// - First strobe edge in long mode switches to normal mode.
// - Missed strobe in normal mode gives one reset timeout pulse.
// - Power-fail flag follows its comparator, no timeout on release.
// - Active-high reset is the complement of the active-low output.
// - Both active-low resets come from one common reset state.
// - Watchdog counter clears on reset and on any strobe edge.
module ssrw_top
    import ssrw_pkg::*;
#(
    parameter longint RST_CYC = RST_TIMEOUT_CYC,
    parameter longint WD_LONG_CYC = WDT_LONG_CYC,
    parameter longint WD_NORM_CYC = WDT_NORM_CYC,
    parameter int MR_DEB = MR_DEB_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Supply comparators and manual request
    input wire ssrw_sense_t sense,
    input wire logic manual_reset_request_n,
    // Watchdog strobe and its float detector
    input wire logic watchdog_strobe_in,
    input wire logic watchdog_strobe_floating,
    // Outputs
    output ssrw_rst_t rst_out,
    output logic power_fail_flag_n
);
    logic [2:0] mr_sync_reg, uv_sync_reg, pf_sync_reg, wdi_sync_reg;
    logic [2:0] flt_sync_reg;
    logic uv_lvl_reg, pf_lvl_reg, flt_lvl_reg;
    logic mr_deb_reg;
    logic [DEB_W-1:0] deb_cnt_reg;
    logic wdi_prev_reg;
    logic [CNT_W-1:0] tmo_cnt_reg;
    logic [CNT_W-1:0] wd_cnt_reg;
    ssrw_wd_t wd_state_reg;
    logic rst_state_reg;
    logic wd_fire_reg;
    logic uv_now, mr_now, wdi_s, wdi_edge, wd_off, cause, wd_limit_hit;
    logic [CNT_W-1:0] wd_limit;

    // Three-stage synchronisers for pin inputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mr_sync_reg <= SYNC_RST_HI;
            uv_sync_reg <= SYNC_RST;
            pf_sync_reg <= SYNC_RST;
            wdi_sync_reg <= SYNC_RST;
            flt_sync_reg <= SYNC_RST_HI;
        end else if (clk_en) begin
            mr_sync_reg <= {mr_sync_reg[1:0], manual_reset_request_n};
            uv_sync_reg <= {uv_sync_reg[1:0],
                sense.primary_low | sense.secondary_low | sense.aux_low};
            pf_sync_reg <= {pf_sync_reg[1:0], sense.pf_low};
            wdi_sync_reg <= {wdi_sync_reg[1:0], watchdog_strobe_in};
            flt_sync_reg <= {flt_sync_reg[1:0], watchdog_strobe_floating};
        end
    end

    // Levels change only once stages two and three agree, both ways
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            uv_lvl_reg <= 1'b0;
            pf_lvl_reg <= 1'b0;
            flt_lvl_reg <= 1'b1;
        end else if (clk_en) begin
            if (uv_sync_reg[1] == uv_sync_reg[2]) begin
                uv_lvl_reg <= uv_sync_reg[2];
            end
            if (pf_sync_reg[1] == pf_sync_reg[2]) begin
                pf_lvl_reg <= pf_sync_reg[2];
            end
            if (flt_sync_reg[1] == flt_sync_reg[2]) begin
                flt_lvl_reg <= flt_sync_reg[2];
            end
        end
    end

    // Agreed levels feed the reset and watchdog logic
    assign uv_now = uv_lvl_reg;
    assign wdi_s = wdi_sync_reg[2];
    assign wdi_edge = (wdi_sync_reg[2] == wdi_sync_reg[1])
        && (wdi_sync_reg[2] != wdi_prev_reg);
    assign wd_off = flt_lvl_reg;

    // Manual request debounce: level must stay stable MR_DEB cycles
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mr_deb_reg <= 1'b1;
            deb_cnt_reg <= '0;
        end else if (clk_en) begin
            if (mr_sync_reg[2] != mr_sync_reg[1]
                || mr_sync_reg[2] == mr_deb_reg) begin
                deb_cnt_reg <= '0;
            end else if (deb_cnt_reg >= DEB_W'(MR_DEB - 1)) begin
                mr_deb_reg <= mr_sync_reg[2];
                deb_cnt_reg <= '0;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 1'b1;
            end
        end
    end
    assign mr_now = !mr_deb_reg;

    // Any cause that holds reset asserted
    assign cause = uv_now | mr_now | wd_fire_reg;

    // Reset state and timeout counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_state_reg <= 1'b1;
            tmo_cnt_reg <= '0;
        end else if (clk_en) begin
            if (cause) begin
                rst_state_reg <= 1'b1;
                tmo_cnt_reg <= '0;
            end else if (rst_state_reg) begin
                if (tmo_cnt_reg >= CNT_W'(RST_CYC - 1)) begin
                    rst_state_reg <= 1'b0;
                    tmo_cnt_reg <= '0;
                end else begin
                    tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
                end
            end
        end
    end

    // Watchdog limit follows the current mode
    assign wd_limit = (wd_state_reg == WD_NORMAL) ? CNT_W'(WD_NORM_CYC - 1)
        : CNT_W'(WD_LONG_CYC - 1);
    assign wd_limit_hit = wd_cnt_reg >= wd_limit;

    // Watchdog mode, counter and expiry
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_state_reg <= WD_LONG;
            wd_cnt_reg <= '0;
            wd_fire_reg <= 1'b0;
            wdi_prev_reg <= 1'b0;
        end else if (clk_en) begin
            // Last agreed strobe level, a glitch cannot fake an edge
            if (wdi_sync_reg[1] == wdi_s) begin
                wdi_prev_reg <= wdi_s;
            end
            wd_fire_reg <= 1'b0;
            if (wd_off) begin
                wd_state_reg <= WD_OFF;
                wd_cnt_reg <= '0;
            end else if (rst_state_reg) begin
                wd_state_reg <= WD_LONG;
                wd_cnt_reg <= '0;
            end else begin
                case (wd_state_reg)
                    WD_OFF: begin
                        wd_state_reg <= WD_LONG;
                        wd_cnt_reg <= '0;
                    end
                    WD_LONG, WD_NORMAL: begin
                        if (wdi_edge) begin
                            wd_state_reg <= WD_NORMAL;
                            wd_cnt_reg <= '0;
                        end else if (wd_limit_hit) begin
                            wd_fire_reg <= 1'b1;
                            wd_cnt_reg <= '0;
                        end else begin
                            wd_cnt_reg <= wd_cnt_reg + 1'b1;
                        end
                    end
                    default: begin
                        wd_state_reg <= WD_LONG;
                        wd_cnt_reg <= '0;
                    end
                endcase
            end
        end
    end

    // Registered outputs: resets from the common reset state or a cause, power-fail flag from its comparator level
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_out <= '{1'b0, 1'b0, 1'b1};
            power_fail_flag_n <= 1'b1;
        end else if (clk_en) begin
            rst_out.reset_out_n_a <= !(rst_state_reg | cause);
            rst_out.reset_out_n_b <= !(rst_state_reg | cause);
            rst_out.reset_out <= rst_state_reg | cause;
            power_fail_flag_n <= !pf_lvl_reg;
        end
    end

    // Both low outputs always equal, high output their complement
    a_outs_agree: assert property (@(posedge ref_clk) disable iff (!reset_n)
        rst_out.reset_out_n_a == rst_out.reset_out_n_b
        && rst_out.reset_out == !rst_out.reset_out_n_a)
        else $error("reset outputs disagree");
    // Undervoltage cause gives reset at next edge
    a_uv_asserts: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && uv_now |=> !rst_out.reset_out_n_a)
        else $error("undervoltage did not assert reset");
    // Watchdog expiry asserts reset state
    a_wd_fire_rst: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && wd_fire_reg |=> rst_state_reg)
        else $error("watchdog expiry missed");
    // Float disables watchdog firing
    a_wd_float_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && wd_off |=> !wd_fire_reg)
        else $error("floating strobe fired");
    // Reset returns watchdog to long mode
    a_wd_long_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && rst_state_reg && !wd_off |=> wd_state_reg == WD_LONG
        && wd_cnt_reg == '0)
        else $error("watchdog not long after reset");
    // Edge in long mode moves to normal
    a_wd_to_norm: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && !wd_off && !rst_state_reg && wdi_edge
        && wd_state_reg == WD_LONG |=> wd_state_reg == WD_NORMAL)
        else $error("strobe edge did not enter normal mode");
    // Cause during timeout restarts count
    a_tmo_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && cause |=> tmo_cnt_reg == '0 && rst_state_reg)
        else $error("timeout not restarted");
    // Release only after counter reaches full timeout
    a_release_tmo: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(rst_state_reg) |-> $past(tmo_cnt_reg) == CNT_W'(RST_CYC - 1))
        else $error("reset released early");
    // Watchdog counter cleared by strobe edge
    a_wd_edge_clr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && !wd_off && wdi_edge |=> wd_cnt_reg == '0)
        else $error("strobe edge did not clear counter");
    // Power-fail flag releases directly once comparator level clears
    a_pf_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && !pf_lvl_reg |=> power_fail_flag_n)
        else $error("power-fail flag did not release");
    // Power-fail flag asserts while comparator reports low
    a_pf_asserts: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && pf_lvl_reg |=> !power_fail_flag_n)
        else $error("power-fail flag did not assert");
    // Manual request keeps reset asserted
    a_mr_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && mr_now |=> rst_out.reset_out)
        else $error("manual request not honoured");
endmodule
`default_nettype wire

// ===== ssrw_cpu_model.sv
// Partner model: processor taking reset and toggling the watchdog strobe
`timescale 1ns/1ps
`default_nettype none
module ssrw_cpu_model #(
    parameter int TOGGLE_CYC = 20
) (
    // Clock and reset seen by the processor
    input wire logic ref_clk,
    input wire logic cpu_reset_n,
    // Scenario controls: pin driven, software hung
    input wire logic drive,
    input wire logic hang,
    // Strobe toward the supervisor
    output logic strobe
);
    int count_reg;

    // Start from a known pin level
    initial begin
        strobe = 1'b0;
        count_reg = 0;
    end

    // Toggle while running; a released pin wanders every cycle
    always @(posedge ref_clk) begin
        if (!drive) begin
            strobe <= ~strobe;
            count_reg <= 0;
        end else if (!cpu_reset_n || hang) begin
            count_reg <= 0;
        end else if (count_reg == TOGGLE_CYC - 1) begin
            strobe <= ~strobe;
            count_reg <= 0;
        end else begin
            count_reg <= count_reg + 1;
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench: scenario tasks for the supply supervisor reset block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssrw_pkg::*;
    localparam int RC = 20;
    localparam int LC = 200;
    localparam int NC = 50;
    logic ref_clk, reset_n, clk_en, mr_n, floating, hang, pf_n, strobe;
    ssrw_sense_t sense;
    ssrw_rst_t rst_out;
    int err_total = 0;
    int num_checks = 0;

    // Design with shortened periods
    ssrw_top #(.RST_CYC(RC), .WD_LONG_CYC(LC), .WD_NORM_CYC(NC),
        .MR_DEB(4)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .sense(sense), .manual_reset_request_n(mr_n),
        .watchdog_strobe_in(strobe), .watchdog_strobe_floating(floating),
        .rst_out(rst_out), .power_fail_flag_n(pf_n));

    // Processor on the far side
    ssrw_cpu_model #(.TOGGLE_CYC(20)) cpu (.ref_clk(ref_clk),
        .cpu_reset_n(rst_out.reset_out_n_a), .drive(!floating),
        .hang(hang), .strobe(strobe));

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Wait for reset (or power-fail flag) to reach v, in lo..hi cycles
    task automatic await_rst(input bit pf, input logic v, input int lo,
            input int hi);
        int n;
        logic s;
        n = 0;
        s = pf ? pf_n : rst_out.reset_out_n_a;
        while (s !== v && n < hi) begin
            tick(1);
            n++;
            s = pf ? pf_n : rst_out.reset_out_n_a;
            check({rst_out.reset_out_n_b, rst_out.reset_out},
                {s | pf, ~(s | pf)});
        end
        check(32'(s === v && n >= lo), 32'h0000_0001);
    endtask

    // Reset must stay released for n cycles
    task automatic quiet(input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            tick(1);
            if (rst_out.reset_out_n_a !== 1'b1) bad++;
        end
        check(32'(bad), 32'h0000_0000);
    endtask

    task automatic s_undervoltage;
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk) sense <= ssrw_sense_t'(4'h8 >> i);
            await_rst(0, 0, 0, 8);
            tick(10);
            @(posedge ref_clk) sense <= '0;
            await_rst(0, 1, RC, RC + 10);
        end
    endtask

    task automatic s_restart;
        @(posedge ref_clk) sense <= ssrw_sense_t'(4'h4);
        await_rst(0, 0, 0, 8);
        @(posedge ref_clk) sense <= '0;
        tick(RC / 2);
        @(posedge ref_clk) sense <= ssrw_sense_t'(4'h2);
        tick(6);
        @(posedge ref_clk) sense <= '0;
        await_rst(0, 1, RC, RC + 10);
    endtask

    task automatic s_manual;
        @(posedge ref_clk) mr_n <= 1'b0;
        @(posedge ref_clk) mr_n <= 1'b1;
        quiet(20);
        @(posedge ref_clk) mr_n <= 1'b0;
        await_rst(0, 0, 0, 14);
        tick(20);
        for (int i = 0; i < 6; i++) @(posedge ref_clk) mr_n <= i[0];
        await_rst(0, 1, RC, RC + 16);
        quiet(40);
    endtask

    task automatic s_power_fail;
        @(posedge ref_clk) sense <= ssrw_sense_t'(4'h1);
        await_rst(1, 0, 0, 8);
        quiet(4);
        @(posedge ref_clk) sense <= '0;
        await_rst(1, 1, 0, 8);
    endtask

    task automatic s_watchdog;
        quiet(3 * NC);
        @(posedge ref_clk) hang <= 1'b1;
        await_rst(0, 0, NC - 22, NC + 10);
        await_rst(0, 1, RC, RC + 10);
        await_rst(0, 0, LC - 5, LC + 10);
        await_rst(0, 1, RC, RC + 10);
        @(posedge ref_clk) hang <= 1'b0;
        @(posedge ref_clk) floating <= 1'b1;
        quiet(LC + 50);
        @(posedge ref_clk) floating <= 1'b0;
    endtask

    // Low enable freezes state, the pending cause is taken afterwards
    task automatic s_freeze;
        @(posedge ref_clk) clk_en <= 1'b0;
        @(posedge ref_clk) sense <= ssrw_sense_t'(4'h8);
        quiet(12);
        @(posedge ref_clk) clk_en <= 1'b1;
        await_rst(0, 0, 1, 8);
        @(posedge ref_clk) sense <= '0;
        await_rst(0, 1, RC, RC + 10);
    endtask

    // Mid-run power-on event: outputs reset, watchdog long again
    task automatic s_reset;
        @(posedge ref_clk) reset_n <= 1'b0;
        tick(1);
        check(32'(rst_out), 32'h0000_0001);
        @(posedge ref_clk) begin
            reset_n <= 1'b1;
            hang <= 1'b1;
        end
        await_rst(0, 1, RC, RC + 10);
        await_rst(0, 0, LC - 5, LC + 10);
        await_rst(0, 1, RC, RC + 10);
        @(posedge ref_clk) hang <= 1'b0;
    endtask

    task automatic summarize;
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        sense = '0;
        mr_n = 1'b1;
        floating = 1'b0;
        hang = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        await_rst(0, 1, RC, RC + 10);
        s_undervoltage();
        s_restart();
        s_manual();
        s_power_fail();
        s_freeze();
        s_watchdog();
        s_reset();
        summarize();
    end

    // Hang guard
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
